// ===== lsa_serdes_top.sv
// serializer/deserializer channels with per-channel clock-to-data skew alignment
`default_nettype none
module lsa_serdes_top (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire lsa_pkg::lsa_wb_req_type wb_req_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic [lsa_pkg::NCH-1:0] rx_serial_i,
   input wire logic [lsa_pkg::NSET-1:0] rx_fwd_clk_i,
   output lsa_pkg::lsa_words_type rx_word_o,
   output logic [lsa_pkg::NCH-1:0] rx_word_valid_o,
   output logic [lsa_pkg::NSET-1:0] rx_lock_o,
   input wire lsa_pkg::lsa_words_type tx_word_i,
   output logic [lsa_pkg::NSET-1:0] tx_take_o,
   output logic [lsa_pkg::NCH-1:0] tx_serial_o,
   output logic [lsa_pkg::NSET-1:0] tx_forwarded_clock_out_o
);
   import lsa_pkg::*;

   lsa_state_type q;
   lsa_state_type d;
   logic [NSET-1:0] take_c;
   logic [NSET-1:0] fedge;
   logic [NSET-1:0] tstrobe;
   logic [NSET-1:0][1:0] tsub_v;
   logic [NSET-1:0][3:0] tbit_n;
   logic [63:0] en_w;
   logic [95:0] pre_w;
   logic [95:0] ph_w;
   logic [9:0] wmask;
   logic [9:0] samp_word;
   logic smp;
   logic bitv;
   logic wb_hit;
   int s;

   // whole block state is one record; registered once, frozen while ce_i is low
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         q <= '0;
         q.mul <= MUL_RST;
         q.wid <= WID_RST;
         q.phase <= {NCH{PH_NOM}};
      end
      else if (ce_i)
      begin
         q <= d;
      end
   end

   // next-state logic for timebases, channels and the register slave
   always_comb
   begin
      d = q;
      take_c = '0;
      fedge = '0;
      tstrobe = '0;
      tsub_v = '0;
      tbit_n = '0;
      smp = 1'b0;
      bitv = 1'b0;
      s = 0;
      samp_word = '0;
      wmask = WORD_ONES >> (4'hA - q.wid);
      en_w = {28'h0, q.en};
      pre_w = {24'h0, q.preset};
      ph_w = {24'h0, q.phase};

      // two-flop synchronisers; only the second stage and later are read
      d.s1 = rx_serial_i;
      d.s2 = q.s1;
      d.s3 = q.s2;
      d.f1 = rx_fwd_clk_i;
      d.f2 = q.f1;
      d.f3 = q.f2;

      // receive timebase per set: link clock edge restarts the bit and phase counters
      for (int k = 0; k < NSET; k++)
      begin
         fedge[k] = q.f2[k] & ~q.f3[k];
         if (fedge[k])
         begin
            d.sub[k] = '0;
            d.bitc[k] = '0;
            // locked only if the last link period held a whole multiple of mul bits
            d.lock[k] = (q.bitc[k] == q.mul - 4'h1) && (q.sub[k] == PH_LAST);
         end
         else
         begin
            d.sub[k] = q.sub[k] + 2'h1;
            if (q.sub[k] == PH_LAST)
            begin
               d.bitc[k] = (q.bitc[k] >= q.mul - 4'h1) ? 4'h0 : q.bitc[k] + 4'h1;
            end
         end
      end

      // receive channels
      for (int c = 0; c < NCH; c++)
      begin
         s = c / SET_CH;
         d.wval[c] = 1'b0;
         // sampling phase: nominal, preset, or learnt from data edges while training
         if (!q.en[c] || q.mode == ALN_OFF)
         begin
            d.phase[c] = PH_NOM;
         end
         else if (q.mode == ALN_PRESET)
         begin
            d.phase[c] = q.preset[c];
         end
         else if (q.train && (q.s2[c] != q.s3[c]))
         begin
            // sample half a bit away from the edge; frozen once train drops
            d.phase[c] = q.sub[s] + PH_HALF;
         end
         smp = (q.sub[s] == q.phase[c]);
         bitv = q.s2[c];
         if (smp)
         begin
            d.shreg[c] = {q.shreg[c][8:0], bitv};
            d.last[c] = bitv;
            // bypass widths take bits straight from the sampler pair
            if (q.wid == 4'h1)
            begin
               samp_word = {9'h0, bitv};
            end
            else if (q.wid == 4'h2)
            begin
               samp_word = {8'h0, q.shreg[c][0], bitv};
            end
            else
            begin
               samp_word = {q.shreg[c][8:0], bitv} & wmask;
            end
            // ones-to-zero step of the training word marks the msb, the first bit of a word
            if (q.train && q.en[c] && q.mode == ALN_SINGLE && q.wid == q.mul
                && q.last[c] && !bitv)
            begin
               d.ccnt[c] = 4'h1;
            end
            else if (q.ccnt[c] >= q.wid - 4'h1)
            begin
               d.ccnt[c] = '0;
               d.word[c] = samp_word;
               d.wval[c] = 1'b1;
            end
            else
            begin
               d.ccnt[c] = q.ccnt[c] + 4'h1;
            end
         end
      end

      // transmit timebase per set: own free-running phase or the receive set's phase
      for (int k = 0; k < NSET; k++)
      begin
         d.tsub[k] = q.tsub[k] + 2'h1;
         tsub_v[k] = q.tx_src_rx ? q.sub[k] : q.tsub[k];
         tstrobe[k] = (tsub_v[k] == PH_LAST);
         tbit_n[k] = (q.tbit[k] >= q.mul - 4'h1) ? 4'h0 : q.tbit[k] + 4'h1;
         if (tstrobe[k])
         begin
            d.tbit[k] = tbit_n[k];
            d.tcnt[k] = (q.tcnt[k] >= q.wid - 4'h1) ? 4'h0 : q.tcnt[k] + 4'h1;
            take_c[k] = (q.tcnt[k] == 4'h0);
         end
         // forwarded clock high for the first half of the mul-bit frame
         d.tclk[k] = ({d.tbit[k], tsub_v[k] + 2'h1} < {1'b0, q.mul, 1'b0});
      end

      // transmit channels, msb of the word first
      // the word is captured on the take strobe; core must have it ready then,
      // since there is no buffer to hold a late word
      for (int c = 0; c < NCH; c++)
      begin
         s = c / SET_CH;
         if (tstrobe[s])
         begin
            if (q.tcnt[s] == 4'h0)
            begin
               d.txd[c] = tx_word_i[c][q.wid - 4'h1];
               d.tsh[c] = {tx_word_i[c][8:0], 1'b0};
            end
            else
            begin
               d.txd[c] = q.tsh[c][q.wid - 4'h1];
               d.tsh[c] = {q.tsh[c][8:0], 1'b0};
            end
         end
      end

      // wishbone slave: one answer per request, ack one cycle after it is taken
      wb_hit = wb_req_i.cyc && wb_req_i.stb && !q.ack;
      d.ack = wb_hit;
      if (wb_hit)
      begin
         case (wb_req_i.adr)
            REG_CTRL: d.rdat = {20'h0, q.train, q.tx_src_rx, q.mode, q.wid, q.mul};
            REG_EN_LO: d.rdat = en_w[31:0];
            REG_EN_HI: d.rdat = en_w[63:32];
            REG_PRE0: d.rdat = pre_w[31:0];
            REG_PRE1: d.rdat = pre_w[63:32];
            REG_PRE2: d.rdat = pre_w[95:64];
            REG_STAT: d.rdat = {30'h0, q.lock};
            REG_PH0: d.rdat = ph_w[31:0];
            REG_PH1: d.rdat = ph_w[63:32];
            REG_PH2: d.rdat = ph_w[95:64];
            default: d.rdat = '0;
         endcase
         if (wb_req_i.we)
         begin
            case (wb_req_i.adr)
               REG_CTRL:
               begin
                  d.rdat = wb_merge({20'h0, q.train, q.tx_src_rx, q.mode, q.wid, q.mul},
                                    wb_req_i.dat, wb_req_i.sel);
                  // illegal factors are ignored so the counters never see them
                  if (legal_factor(d.rdat[CTRL_MUL_LSB +: 4]))
                  begin
                     d.mul = d.rdat[CTRL_MUL_LSB +: 4];
                  end
                  if (legal_factor(d.rdat[CTRL_WID_LSB +: 4]))
                  begin
                     d.wid = d.rdat[CTRL_WID_LSB +: 4];
                  end
                  d.mode = lsa_mode_type'(d.rdat[CTRL_MODE_LSB +: 2]);
                  d.tx_src_rx = d.rdat[CTRL_TXSRC_BIT];
                  d.train = d.rdat[CTRL_TRAIN_BIT];
                  d.rdat = q.rdat;
               end
               REG_EN_LO:
               begin
                  // low word only: channels 32 to 35 live in the high register
                  // and must keep their enables across a low-word write
                  d.en[31:0] = wb_merge(en_w[31:0], wb_req_i.dat, wb_req_i.sel);
               end
               REG_EN_HI: d.en[NCH-1:32] = 4'(wb_merge(en_w[63:32], wb_req_i.dat,
                                                      wb_req_i.sel));
               REG_PRE0:
               begin
                  pre_w[31:0] = wb_merge(pre_w[31:0], wb_req_i.dat, wb_req_i.sel);
                  d.preset = pre_w[71:0];
               end
               REG_PRE1:
               begin
                  pre_w[63:32] = wb_merge(pre_w[63:32], wb_req_i.dat, wb_req_i.sel);
                  d.preset = pre_w[71:0];
               end
               REG_PRE2:
               begin
                  pre_w[95:64] = wb_merge(pre_w[95:64], wb_req_i.dat, wb_req_i.sel);
                  d.preset = pre_w[71:0];
               end
               default: d.rdat = q.rdat;
            endcase
            // writes return the previous read data untouched
            d.rdat = q.rdat;
         end
      end
   end

   // outputs straight from the state record; take is a combinational handshake
   assign tx_take_o = take_c & {NSET{ce_i}};
   assign rx_word_o = q.word;
   assign rx_word_valid_o = q.wval;
   assign rx_lock_o = q.lock;
   assign tx_serial_o = q.txd;
   assign tx_forwarded_clock_out_o = q.tclk;
   assign wb_dat_o = q.rdat;
   assign wb_ack_o = q.ack;
endmodule
`default_nettype wire

// ===== lsa_pkg.sv
// package for the skew-aligning serializer/deserializer block
`default_nettype none
package lsa_pkg;
   // channel organisation
   localparam int NCH = 36;
   localparam int NSET = 2;
   localparam int SET_CH = 18;
   localparam int WMAX = 10;
   // timing: one bit period is four clock cycles, one clock per quarter-bit phase step
   localparam int CLK_NS = 4;
   localparam int BIT_NS = 16;
   localparam int BIT_CYC = BIT_NS / CLK_NS;
   localparam logic [1:0] PH_LAST = 2'(BIT_CYC - 1);
   localparam logic [1:0] PH_HALF = 2'(BIT_CYC / 2);
   localparam logic [1:0] PH_NOM = 2'(BIT_CYC / 2);
   // register byte offsets
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_EN_LO = 8'h04;
   localparam logic [7:0] REG_EN_HI = 8'h08;
   localparam logic [7:0] REG_PRE0 = 8'h0C;
   localparam logic [7:0] REG_PRE1 = 8'h10;
   localparam logic [7:0] REG_PRE2 = 8'h14;
   localparam logic [7:0] REG_STAT = 8'h18;
   localparam logic [7:0] REG_PH0 = 8'h1C;
   localparam logic [7:0] REG_PH1 = 8'h20;
   localparam logic [7:0] REG_PH2 = 8'h24;
   // control field positions
   localparam int CTRL_MUL_LSB = 0;
   localparam int CTRL_WID_LSB = 4;
   localparam int CTRL_MODE_LSB = 8;
   localparam int CTRL_TXSRC_BIT = 10;
   localparam int CTRL_TRAIN_BIT = 11;
   // reset values and the full-width word mask
   localparam logic [3:0] MUL_RST = 4'hA;
   localparam logic [3:0] WID_RST = 4'hA;
   localparam logic [9:0] WORD_ONES = 10'h3FF;

   typedef enum logic [1:0] {ALN_OFF, ALN_SINGLE, ALN_MULTI, ALN_PRESET} lsa_mode_type;

   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [3:0] sel;
      logic [7:0] adr;
      logic [31:0] dat;
   } lsa_wb_req_type;

   typedef logic [NCH-1:0][WMAX-1:0] lsa_words_type;

   typedef struct packed {
      logic [3:0] mul;
      logic [3:0] wid;
      lsa_mode_type mode;
      logic tx_src_rx;
      logic train;
      logic [NCH-1:0] en;
      logic [NCH-1:0][1:0] preset;
      logic [NCH-1:0] s1;
      logic [NCH-1:0] s2;
      logic [NCH-1:0] s3;
      logic [NSET-1:0] f1;
      logic [NSET-1:0] f2;
      logic [NSET-1:0] f3;
      logic [NSET-1:0][1:0] sub;
      logic [NSET-1:0][3:0] bitc;
      logic [NSET-1:0] lock;
      logic [NCH-1:0][1:0] phase;
      logic [NCH-1:0][3:0] ccnt;
      logic [NCH-1:0] last;
      logic [NCH-1:0][9:0] shreg;
      lsa_words_type word;
      logic [NCH-1:0] wval;
      logic [NSET-1:0][1:0] tsub;
      logic [NSET-1:0][3:0] tbit;
      logic [NSET-1:0][3:0] tcnt;
      logic [NCH-1:0][9:0] tsh;
      logic [NCH-1:0] txd;
      logic [NSET-1:0] tclk;
      logic ack;
      logic [31:0] rdat;
   } lsa_state_type;

   // legal multiplication and word-width factors: 1, 2, 4..10
   function automatic logic legal_factor(input logic [3:0] v);
      return (v == 4'h1) || (v == 4'h2) || ((v >= 4'h4) && (v <= 4'hA));
   endfunction

   // byte-lane merge for wishbone writes
   function automatic logic [31:0] wb_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                             input logic [3:0] sel);
      logic [31:0] r;
      r = old_v;
      for (int b = 0; b < 4; b++)
      begin
         if (sel[b])
         begin
            r[b*8 +: 8] = new_v[b*8 +: 8];
         end
      end
      return r;
   endfunction
endpackage
`default_nettype wire

// ===== lsa_serdes_top_sva.sv
// port-level assertions for the serializer/deserializer block
`default_nettype none
module lsa_serdes_top_sva (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire lsa_pkg::lsa_wb_req_type wb_req_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire lsa_pkg::lsa_words_type rx_word_o,
   input wire logic [35:0] rx_word_valid_o,
   input wire logic [1:0] tx_take_o,
   input wire logic [35:0] tx_serial_o
);
   import lsa_pkg::*;
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // register bus answers one cycle after taking, for one cycle only
   sequence s_req;
      wb_req_i.cyc && wb_req_i.stb && !wb_ack_o && ce_i;
   endsequence
   sequence s_take;
      tx_take_o[0] && ce_i;
   endsequence
   property p_ack_lat;
      s_req |=> wb_ack_o;
   endproperty
   property p_ack_pulse;
      wb_ack_o && ce_i |=> !wb_ack_o;
   endproperty
   property p_ack_cause;
      $rose(wb_ack_o) |-> $past(wb_req_i.cyc && wb_req_i.stb);
   endproperty
   property p_unmap;
      wb_ack_o && !wb_req_i.we && wb_req_i.adr == 8'hFC |-> wb_dat_o == 32'h0;
   endproperty
   // a serial bit stands four clocks after the word is taken
   property p_tx_hold;
      s_take |=> ##1 $stable(tx_serial_o) [*3];
   endproperty
   property p_take_gap;
      s_take |=> !tx_take_o[0] [*3];
   endproperty
   property p_val_gap;
      rx_word_valid_o[0] |=> !rx_word_valid_o[0] [*3];
   endproperty
   property p_word_hold;
      $changed(rx_word_o[0]) |-> rx_word_valid_o[0];
   endproperty
   a_ack_lat: assert property (p_ack_lat) else $error("ack not one cycle after request");
   a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
   a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
   a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
   a_tx_hold: assert property (p_tx_hold) else $error("serial bit not held");
   a_take_gap: assert property (p_take_gap) else $error("take too close");
   a_val_gap: assert property (p_val_gap) else $error("words too close");
   a_word_hold: assert property (p_word_hold) else $error("word changed without valid");
endmodule
bind lsa_serdes_top lsa_serdes_top_sva chk_u (.clk_i, .rst_i, .ce_i, .wb_req_i, .wb_dat_o,
   .wb_ack_o, .rx_word_o, .rx_word_valid_o, .tx_take_o, .tx_serial_o);
`default_nettype wire

// ===== lsa_far_end.sv
// far-end transmitter model feeding the receive lanes
`default_nettype none
module lsa_far_end (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [3:0] mul_i,
   input wire logic [3:0] wid_i,
   input wire logic [9:0] pat_i,
   output logic [35:0] ser_o,
   output logic [1:0] fclk_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] sub_q;
   logic [3:0] bit_q;
   logic [3:0] fb_q;
   logic [2:0] hist_q;
   // four clocks a bit, word sent msb first, frame of mul bits
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         {sub_q, bit_q, fb_q, hist_q} <= '0;
      end
      else
      begin
         sub_q <= sub_q + 2'h1;
         hist_q <= {hist_q[1:0], pat_i[wid_i - 4'h1 - bit_q]};
         if (sub_q == 2'h3)
         begin
            bit_q <= (bit_q >= wid_i - 4'h1) ? 4'h0 : bit_q + 4'h1;
            fb_q <= (fb_q == mul_i - 4'h1) ? 4'h0 : fb_q + 4'h1;
         end
      end
   end
   // fixed lane skew of up to two clocks, inside half a bit
   always_comb
   begin
      for (int c = 0; c < 36; c++)
      begin
         ser_o[c] = hist_q[c % 3];
      end
   end
   assign fclk_o = {2{fb_q < (mul_i >> 1)}};
endmodule
`default_nettype wire

// ===== tb_lsa_serdes_skew_align.sv
// self-checking bench for the serializer/deserializer block
`default_nettype none
module tb_lsa_serdes_skew_align;
   timeunit 1ns;
   timeprecision 1ps;
   import lsa_pkg::*;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   lsa_wb_req_type wbq = '0;
   logic [31:0] q;
   logic [31:0] rnd;
   lsa_words_type rxw;
   lsa_words_type txw = '0;
   logic [35:0] rxv;
   logic [35:0] ser;
   logic [35:0] tser;
   int cnt;
   logic [1:0] lock;
   logic [1:0] take;
   logic [1:0] fclk;
   logic [1:0] tfc;
   logic [3:0] pwid = 4'h8;
   logic [9:0] pat = '0;
   logic [31:0] wdat;
   logic wack;
   int mismatches = 0;
   int compares = 0;
   int seed = 32'hbdd81ab3;
   always #2 clk_i = ~clk_i;
   lsa_serdes_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .wb_req_i(wbq),
      .wb_dat_o(wdat), .wb_ack_o(wack), .rx_serial_i(ser), .rx_fwd_clk_i(fclk),
      .rx_word_o(rxw), .rx_word_valid_o(rxv), .rx_lock_o(lock), .tx_word_i(txw),
      .tx_take_o(take), .tx_serial_o(tser), .tx_forwarded_clock_out_o(tfc));
   lsa_far_end fe_u (.clk_i(clk_i), .rst_i(rst_i), .mul_i(4'h8), .wid_i(pwid),
      .pat_i(pat), .ser_o(ser), .fclk_o(fclk));
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      compares++;
      if (s !== e)
      begin
         mismatches++;
         $display("unexpected at %0t: seen %h expected %h", $time, s, e);
      end
   endtask
   task automatic report_and_stop();
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // classic single cycle, held until ack is sampled
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clk_i);
      wbq <= '{1'b1, 1'b1, w, 4'hF, a, d};
      n = 0;
      do begin @(posedge clk_i); n++; end while (wack !== 1'b1 && n < 40);
      if (n < 40)
      begin
         q = wdat;
         wbq <= '0;
      end
      else
      begin
         mismatches++;
         report_and_stop();
      end
   endtask
   // one word out on every lane, checked on lanes 0 to 31, msb first, then the next take
   task automatic txc(input logic [3:0] w);
      int n;
      logic [9:0] v;
      wb(1'b1, REG_CTRL, {24'h0, w, 4'h8});
      v = 10'($random(seed));
      txw <= {36{v}};
      n = 0;
      do begin @(posedge clk_i); n++; end while (take[0] !== 1'b1 && n < 100);
      if (n < 100)
      begin
         for (int k = w - 1; k >= 0; k--)
         begin
            @(posedge clk_i);
            chk(tser[31:0], {32{v[k]}});
            repeat (3) @(posedge clk_i);
         end
         chk(take, 2'b11);
      end
      else
      begin
         mismatches++;
         report_and_stop();
      end
   endtask
   initial
   begin
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      wb(1'b0, REG_CTRL, 0); chk(q, 32'h000000AA);
      wb(1'b1, REG_CTRL, 32'h83); wb(1'b0, REG_CTRL, 0); chk(q, 32'h8A);
      wb(1'b1, REG_CTRL, 32'h3A); wb(1'b0, REG_CTRL, 0); chk(q, 32'h8A);
      for (int f = 1; f <= 10; f++)
      begin
         if (f != 3)
         begin
            wb(1'b1, REG_CTRL, {24'h0, 4'(f), 4'(11 - f)});
            wb(1'b0, REG_CTRL, 0); chk(q, {24'h0, 4'(f), (f == 8) ? 4'(4) : 4'(11 - f)});
         end
      end
      wb(1'b0, 8'hFC, 0); chk(q, 32'h0);
      wb(1'b1, REG_EN_LO, 32'hFFFFFFFF);
      wb(1'b1, REG_EN_HI, 32'hF); wb(1'b0, REG_EN_HI, 0); chk(q, 32'hF);
      rnd = $random(seed);
      wb(1'b1, REG_PRE0, rnd);
      wb(1'b1, REG_CTRL, 32'h388); wb(1'b0, REG_PH0, 0); chk(q, rnd);
      wb(1'b1, REG_EN_LO, 0); wb(1'b0, REG_PH0, 0); chk(q, 32'hAAAAAAAA);
      wb(1'b1, REG_EN_LO, 32'hFFFFFFFF);
      // single-bit training, width equal to multiplier
      pat <= 10'h00F;
      wb(1'b1, REG_CTRL, 32'h988);
      repeat (800) @(posedge clk_i);
      wb(1'b1, REG_CTRL, 32'h188);
      repeat (200) @(posedge clk_i);
      chk(lock, 2'b11);
      wb(1'b0, REG_STAT, 0); chk(q, 32'h3);
      for (int c = 0; c < 36; c++) chk(rxw[c], 10'h00F);
      pat <= {2'h0, rnd[7:0]};
      repeat (200) @(posedge clk_i);
      for (int c = 0; c < 36; c++) chk(rxw[c], {2'h0, rnd[7:0]});
      // one valid per eight-bit word of four clocks a bit
      cnt = 0;
      repeat (320)
      begin
         @(posedge clk_i);
         cnt += rxv[0];
      end
      chk(cnt, 10);
      // multi-bit training with width six under multiplier eight
      pat <= 10'h015;
      pwid <= 4'h6;
      wb(1'b1, REG_CTRL, 32'hA68);
      repeat (800) @(posedge clk_i);
      wb(1'b1, REG_CTRL, 32'h268);
      repeat (200) @(posedge clk_i);
      chk(rxw[0] == 10'h015 || rxw[0] == 10'h02A, 1);
      foreach (rnd[i]) if (i < 4) txc(i == 0 ? 4'h1 : i == 1 ? 4'h2 : i == 2 ? 4'h5 : 4'hA);
      // forwarded clock high for half of an eight-bit frame
      cnt = 0;
      repeat (32)
      begin
         @(posedge clk_i);
         cnt += tfc[0];
      end
      chk(cnt, 16);
      report_and_stop();
   end
endmodule
`default_nettype wire
